// [design/mcm_pkg.sv]
// shared constants and types of the macrocell mode block
package mcm_pkg;
   localparam int NUM_CELLS      = 8;
   localparam int NUM_DED_IN     = 8;
   localparam int ARRAY_INPUTS   = 16;
   localparam int PT_WIDTH       = 2 * ARRAY_INPUTS;
   localparam int PT_PER_CELL    = 8;
   localparam int PT_COMPLEX     = 7;
   localparam int PT_SIMPLE      = 8;
   localparam int MAX_IO_COMPLEX = 6;
   localparam int OUTER_LO       = 0;
   localparam int OUTER_HI       = 7;
   localparam int CENTRE_LO      = 3;
   localparam int CENTRE_HI      = 4;
   localparam int SIG_BITS       = 64;
   localparam int SIG_FUSE_FIRST = 2056;
   localparam int SIG_FUSE_LAST  = 2119;
   localparam int MODE_SYNC_FUSE = 2192;
   localparam int MODE_ARCH_FUSE = 2193;
   localparam logic [63:0] SIG_RESET = 64'h0;
   localparam logic [7:0]  POL_RESET = 8'h00;
   localparam logic [7:0]  IOC_RESET = 8'h00;
   localparam logic [1:0]  MODE_RESET = 2'h1;
   // avalon register byte addresses
   localparam logic [4:0] REG_MODE    = 5'h00;
   localparam logic [4:0] REG_POL     = 5'h04;
   localparam logic [4:0] REG_IOC     = 5'h08;
   localparam logic [4:0] REG_SIG_LO  = 5'h0c;
   localparam logic [4:0] REG_SIG_HI  = 5'h10;
   localparam logic [4:0] REG_STATUS  = 5'h14;
   localparam logic [4:0] REG_PTSEL   = 5'h18;
   localparam logic [4:0] REG_PTDATA  = 5'h1c;
   localparam int MODE_SYNC_POS = 1;
   localparam int MODE_ARCH_POS = 0;
   // {mode_sync_bit, mode_arch_bit0}
   typedef enum logic [1:0] {
      MCM_REGISTERED = 2'b10,
      MCM_COMPLEX    = 2'b11,
      MCM_SIMPLE     = 2'b01,
      MCM_ILLEGAL    = 2'b00
   } mcm_mode_t;
endpackage : mcm_pkg

// [design/mcm_cfg_if.sv]
// configuration carried from the register file to the macrocell array
`timescale 1ns/1ns
`default_nettype none
interface mcm_cfg_if;
   logic [1:0]                        mode;
   logic [mcm_pkg::NUM_CELLS-1:0]     pol;
   logic [mcm_pkg::NUM_CELLS-1:0]     ioc;
   logic [mcm_pkg::NUM_CELLS*mcm_pkg::PT_PER_CELL*mcm_pkg::PT_WIDTH-1:0] fuses;
   modport src (output mode, output pol, output ioc, output fuses);
   modport dst (input mode, input pol, input ioc, input fuses);
endinterface : mcm_cfg_if
`default_nettype wire

// [design/mcm_cell.sv]
// one output macrocell: product terms, sum, polarity and enable
`timescale 1ns/1ns
`default_nettype none
module mcm_cell #(
   parameter int N_IN = 16,
   parameter int N_PT = 8
) (
   input  wire logic [N_IN-1:0]        array_in,
   input  wire logic [N_PT*2*N_IN-1:0] fuse_in,
   input  wire logic [1:0]             mode_in,
   input  wire logic                   pol_in,
   input  wire logic                   ioc_in,
   input  wire logic                   no_out_in,
   output logic                        out_data_out,
   output logic                        out_en_out
);
   logic [N_PT-1:0] pt;
   logic [2*N_IN-1:0] lits;
   logic sum_c, sum_s;
   assign lits = {~array_in, array_in};
   genvar g;
   generate
      for (g = 0; g < N_PT; g++) begin : g_pt
         // an unprogrammed (all ones) term reads every literal and its inverse, so stays low
         assign pt[g] = &(~fuse_in[g*2*N_IN +: 2*N_IN] | lits);
      end
   endgenerate
   assign sum_c = |pt[N_PT-2:0];
   assign sum_s = |pt;
   always_comb begin
      out_data_out = 1'b0;
      out_en_out   = 1'b0;
      case (mode_in)
         mcm_pkg::MCM_COMPLEX: begin
            out_data_out = sum_c ^ pol_in;
            out_en_out   = pt[N_PT-1] & ~no_out_in;
         end
         mcm_pkg::MCM_SIMPLE: begin
            out_data_out = sum_s ^ pol_in;
            out_en_out   = ~ioc_in;
         end
         default: begin
            out_data_out = 1'b0;
            out_en_out   = 1'b0;
         end
      endcase
   end
endmodule : mcm_cell
`default_nettype wire

// [design/mcm_top.sv]
// macrocell array in complex and simple modes with avalon configuration port
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module mcm_top #(
   parameter int NCELL = 8
) (
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic [4:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   output logic [1:0]       avs_response_out,
   input  wire logic [7:0]  ded_pin_in,
   input  wire logic        aux_pin_a_in,
   input  wire logic        aux_pin_b_in,
   input  wire logic [7:0]  io_pin_in,
   output logic [7:0]       io_pin_out,
   output logic [7:0]       io_pin_oe_n_out,
   output logic             mode_fault_out
);
   localparam int NI = mcm_pkg::ARRAY_INPUTS;
   localparam int NP = mcm_pkg::PT_PER_CELL;
   localparam int PW = mcm_pkg::PT_WIDTH;
   localparam int NROW = NCELL * NP;

   if (NCELL != mcm_pkg::NUM_CELLS) begin : g_chk
      $error("mcm_top supports exactly eight macrocells");
   end

   mcm_cfg_if cfg ();

   // ---------------- pin synchronisers ----------------
   logic [9:0] pin_s1, pin_s2;
   logic [7:0] io_s1, io_s2;
   logic [9:0] next_pin_s1;
   logic [7:0] next_io_s1;
   always_comb begin
      next_pin_s1 = {aux_pin_b_in, aux_pin_a_in, ded_pin_in};
      next_io_s1  = io_pin_in;
   end
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pin_s1 <= 10'h000;
         pin_s2 <= 10'h000;
         io_s1  <= 8'h00;
         io_s2  <= 8'h00;
      end else begin
         pin_s1 <= next_pin_s1;
         pin_s2 <= pin_s1;
         io_s1  <= next_io_s1;
         io_s2  <= io_s1;
      end
   end

   // ---------------- register file ----------------
   logic [1:0]  mode;
   logic [7:0]  pol, ioc;
   logic [63:0] sig;
   logic [5:0]  pt_sel;
   logic [PW-1:0] fuse_mem [NROW];
   logic [1:0]  next_mode;
   logic [7:0]  next_pol, next_ioc;
   logic [63:0] next_sig;
   logic [5:0]  next_pt_sel;
   logic [31:0] next_rdata;
   logic [1:0]  next_resp;
   logic        next_ack;
   logic        ack;
   logic [31:0] rdata;
   logic [1:0]  resp;
   logic        fuse_we;
   logic [31:0] fuse_wdata;
   logic        ioc_bad;
   logic [3:0]  io_count;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
      end
      return r;
   endfunction : merge

   // complex mode: outer cells never I/O, and no more than six I/O cells
   always_comb begin
      io_count = 4'h0;
      for (int i = 0; i < 8; i++) begin
         io_count = io_count + {3'h0, ioc[i]};
      end
   end

   // a write to the I/O mask that breaks the mode limits is refused with slave error
   function automatic logic ioc_legal(input logic [1:0] m, input logic [7:0] v);
      logic [3:0] c;
      c = 4'h0;
      for (int i = 0; i < 8; i++) begin
         c = c + {3'h0, v[i]};
      end
      if (m == mcm_pkg::MCM_COMPLEX) begin
         return !v[mcm_pkg::OUTER_LO] && !v[mcm_pkg::OUTER_HI] &&
                (c <= 4'(mcm_pkg::MAX_IO_COMPLEX));
      end
      if (m == mcm_pkg::MCM_SIMPLE) begin
         return !v[mcm_pkg::CENTRE_LO] && !v[mcm_pkg::CENTRE_HI];
      end
      return 1'b1;
   endfunction : ioc_legal

   always_comb begin
      next_mode   = mode;
      next_pol    = pol;
      next_ioc    = ioc;
      next_sig    = sig;
      next_pt_sel = pt_sel;
      next_rdata  = 32'h0;
      next_resp   = 2'h0;
      next_ack    = 1'b0;
      fuse_we     = 1'b0;
      fuse_wdata  = 32'h0;
      if ((avs_read_in || avs_write_in) && !ack) begin
         next_ack = 1'b1;
         if (avs_write_in) begin
            case (avs_address_in)
               mcm_pkg::REG_MODE: begin
                  // mode change is accepted only if the current I/O mask stays legal in the new mode
                  if (avs_byteenable_in[0] &&
                      ioc_legal(avs_writedata_in[1:0], ioc))
                     next_mode = avs_writedata_in[1:0];
                  else if (avs_byteenable_in[0])
                     next_resp = 2'h2;
               end
               mcm_pkg::REG_POL: begin
                  if (avs_byteenable_in[0]) next_pol = avs_writedata_in[7:0];
               end
               mcm_pkg::REG_IOC: begin
                  if (avs_byteenable_in[0] && ioc_legal(mode, avs_writedata_in[7:0]))
                     next_ioc = avs_writedata_in[7:0];
                  else if (avs_byteenable_in[0])
                     next_resp = 2'h2;
               end
               mcm_pkg::REG_SIG_LO: next_sig[31:0]  = merge(sig[31:0], avs_writedata_in,
                                                            avs_byteenable_in);
               mcm_pkg::REG_SIG_HI: next_sig[63:32] = merge(sig[63:32], avs_writedata_in,
                                                            avs_byteenable_in);
               mcm_pkg::REG_PTSEL: begin
                  if (avs_byteenable_in[0]) next_pt_sel = avs_writedata_in[5:0];
               end
               mcm_pkg::REG_PTDATA: begin
                  fuse_we    = 1'b1;
                  fuse_wdata = merge(fuse_mem[pt_sel], avs_writedata_in, avs_byteenable_in);
               end
               mcm_pkg::REG_STATUS: next_resp = 2'h0;
               default: next_resp = 2'h3;
            endcase
         end else begin
            case (avs_address_in)
               mcm_pkg::REG_MODE:   next_rdata = {30'h0, mode};
               mcm_pkg::REG_POL:    next_rdata = {24'h0, pol};
               mcm_pkg::REG_IOC:    next_rdata = {24'h0, ioc};
               mcm_pkg::REG_SIG_LO: next_rdata = sig[31:0];
               mcm_pkg::REG_SIG_HI: next_rdata = sig[63:32];
               mcm_pkg::REG_STATUS: next_rdata = {4'h0, io_s2, pin_s2, io_count, 4'h0,
                                                  cfg.fuses[0], mode_fault_out};
               mcm_pkg::REG_PTSEL:  next_rdata = {26'h0, pt_sel};
               mcm_pkg::REG_PTDATA: next_rdata = fuse_mem[pt_sel];
               default: begin
                  next_rdata = 32'h0;
                  next_resp  = 2'h3;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mode   <= mcm_pkg::MODE_RESET;
         pol    <= mcm_pkg::POL_RESET;
         ioc    <= mcm_pkg::IOC_RESET;
         sig    <= mcm_pkg::SIG_RESET;
         pt_sel <= 6'h00;
         ack    <= 1'b0;
         rdata  <= 32'h0;
         resp   <= 2'h0;
      end else begin
         mode   <= next_mode;
         pol    <= next_pol;
         ioc    <= next_ioc;
         sig    <= next_sig;
         pt_sel <= next_pt_sel;
         ack    <= next_ack;
         rdata  <= next_rdata;
         resp   <= next_resp;
      end
   end

   // fuse memory has no reset: an unprogrammed row is cleared by software
   always_ff @(posedge clk_in) begin
      if (fuse_we) fuse_mem[pt_sel] <= fuse_wdata;
   end

   assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack;
   assign avs_readdata_out    = rdata;
   assign avs_response_out    = resp;
   assign mode_fault_out      = (mode == mcm_pkg::MCM_REGISTERED) ||
                                (mode == mcm_pkg::MCM_ILLEGAL);

   assign cfg.mode = mode;
   assign cfg.pol  = pol;
   assign cfg.ioc  = ioc;
   genvar r;
   generate
      for (r = 0; r < NROW; r++) begin : g_fuse
         assign cfg.fuses[r*PW +: PW] = fuse_mem[r];
      end
   endgenerate

   // ---------------- array input selection ----------------
   logic [7:0] cell_d, cell_en;
   logic [7:0] fb;
   logic [NI-1:0] array_in;
   always_comb begin
      fb = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (cfg.mode == mcm_pkg::MCM_COMPLEX) begin
            // the pin level returns, driven or floated; reading the pin, not the
            // term, keeps the array free of a combinational loop
            fb[i] = io_s2[i];
         end else if (cfg.mode == mcm_pkg::MCM_SIMPLE) begin
            fb[i] = cfg.ioc[i] ? io_s2[i] : 1'b0;
         end
      end
      if (cfg.mode == mcm_pkg::MCM_COMPLEX) begin
         fb[mcm_pkg::OUTER_HI] = pin_s2[8];
         fb[mcm_pkg::OUTER_LO] = pin_s2[9];
      end else if (cfg.mode == mcm_pkg::MCM_SIMPLE) begin
         // adjacent-cell routing: columns 1-2 and 5-6 carry the pin of the neighbour nearer the centre, columns 3 and 4 read low
         fb = {fb[6:4], 1'b0, 1'b0, fb[3:1]};
         fb[mcm_pkg::OUTER_HI] = pin_s2[8];
         fb[mcm_pkg::OUTER_LO] = pin_s2[9];
      end
      array_in = {fb, pin_s2[7:0]};
   end

   genvar c;
   generate
      for (c = 0; c < 8; c++) begin : g_cell
         mcm_cell #(.N_IN(NI), .N_PT(NP)) u_cell (
            .array_in     (array_in),
            .fuse_in      (cfg.fuses[c*NP*PW +: NP*PW]),
            .mode_in      (cfg.mode),
            .pol_in       (cfg.pol[c]),
            .ioc_in       (cfg.ioc[c]),
            .no_out_in    (1'b0),
            .out_data_out (cell_d[c]),
            .out_en_out   (cell_en[c])
         );
      end
   endgenerate

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         io_pin_out      <= 8'h00;
         io_pin_oe_n_out <= 8'hff;
      end else begin
         io_pin_out      <= cell_d;
         io_pin_oe_n_out <= ~cell_en;
      end
   end

   // ---------------- assertions ----------------
   centre_out_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      mode == mcm_pkg::MCM_SIMPLE |-> !ioc[3] && !ioc[4])
      else $error("centre cell configured as input in simple mode");
   outer_noio_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      mode == mcm_pkg::MCM_COMPLEX |-> !ioc[0] && !ioc[7] && io_count <= 4'h6)
      else $error("complex mode I/O limits broken");
   simple_drive_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (cfg.mode == mcm_pkg::MCM_SIMPLE && $stable(cfg.mode)) |=>
      io_pin_oe_n_out == $past(cfg.ioc))
      else $error("simple mode output enable wrong");
   oe_follow_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      1'b1 |=> io_pin_oe_n_out == ~$past(cell_en))
      else $error("pin enable does not follow enable term");
   fault_idle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      mode_fault_out |-> cell_en == 8'h00)
      else $error("cells driving in unsupported mode");
   ded_in_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (mode == mcm_pkg::MCM_COMPLEX) |-> array_in[NI-1] == pin_s2[8])
      else $error("dedicated input not on outer feedback");
   bus_ack_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (avs_read_in && avs_waitrequest_out) |=> !avs_waitrequest_out)
      else $error("read not answered in one cycle");
   sig_read_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (avs_read_in && avs_waitrequest_out && avs_address_in == mcm_pkg::REG_SIG_HI)
      |=> avs_readdata_out == $past(sig[63:32]))
      else $error("signature high word wrong");
   cv_complex_c: cover property (@(posedge clk_in) mode == mcm_pkg::MCM_COMPLEX && |cell_en);
   cv_simple_c:  cover property (@(posedge clk_in) mode == mcm_pkg::MCM_SIMPLE && |cell_d);
   cv_reject_c:  cover property (@(posedge clk_in) resp == 2'h2);
endmodule : mcm_top
`default_nettype wire

// [sim/mcm_board.sv]
// board glue model: drives the block's inputs and resolves the shared pin wires
`timescale 1ns/1ns
`default_nettype none
module mcm_board (
   input  wire logic [7:0] ded_drv_in,
   input  wire logic [1:0] aux_drv_in,
   input  wire logic [7:0] io_drv_in,
   input  wire logic [7:0] pin_val_in,
   input  wire logic [7:0] pin_oe_n_in,
   output logic [7:0]      ded_pin_out,
   output logic            aux_a_out,
   output logic            aux_b_out,
   output logic [7:0]      io_level_out
);
   assign ded_pin_out = ded_drv_in;
   // former clock and enable pins carry plain data only
   assign aux_a_out = aux_drv_in[0];
   assign aux_b_out = aux_drv_in[1];
   // a floated cell shows the board's own drive, never a stale block value
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         io_level_out[i] = pin_oe_n_in[i] ? io_drv_in[i] : pin_val_in[i];
      end
   end
endmodule : mcm_board
`default_nettype wire

// [sim/tb_macrocell_complex_simple_modes.sv]
// self-checking bench for the macrocell array in complex and simple modes
`timescale 1ns/1ns
`default_nettype none
module tb_macrocell_complex_simple_modes;
   logic        clk_in, sys_rst_in, rd, wr, wreq, fault, aux_a, aux_b;
   logic [4:0]  adr;
   logic [31:0] wd, rdata, q, sig_lo, sig_hi;
   logic [1:0]  resp, r, aux_drv;
   logic [7:0]  ded_drv, io_drv, ded, io_lvl, pin_out, pin_oe_n, pol, ioc;
   logic [31:0] fz [64];
   int          err_total = 0;
   int          checks = 0;
   int          cyc = 0;

   mcm_top #(.NCELL(8)) DUT (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
      .avs_response_out(resp), .ded_pin_in(ded), .aux_pin_a_in(aux_a),
      .aux_pin_b_in(aux_b), .io_pin_in(io_lvl), .io_pin_out(pin_out),
      .io_pin_oe_n_out(pin_oe_n), .mode_fault_out(fault));

   mcm_board board (
      .ded_drv_in(ded_drv), .aux_drv_in(aux_drv), .io_drv_in(io_drv),
      .pin_val_in(pin_out), .pin_oe_n_in(pin_oe_n), .ded_pin_out(ded),
      .aux_a_out(aux_a), .aux_b_out(aux_b), .io_level_out(io_lvl));

   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks=%0d errors=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_in);
      adr <= a;
      wd  <= d;
      wr  <= w;
      rd  <= ~w;
      // request stands until an edge sees waitrequest low; only the bench timeout ends a hang
      do begin
         @(posedge clk_in);
      end while (wreq !== 1'b0);
      q = rdata;
      r = resp;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task automatic wchk(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      bus(1'b1, a, d);
      chk(32'(r), 32'(er));
   endtask : wchk

   task automatic rchk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
      chk(32'(r), 32'h0);
   endtask : rchk

   task automatic rowset(input int i, input logic [31:0] v);
      fz[i] = v;
      wchk(mcm_pkg::REG_PTSEL, 32'(i), 2'h0);
      wchk(mcm_pkg::REG_PTDATA, v, 2'h0);
   endtask : rowset

   task automatic wcfg(input logic [7:0] m);
      pol = 8'($urandom);
      ioc = 8'($urandom) & m;
      wchk(mcm_pkg::REG_POL, {24'h0, pol}, 2'h0);
      wchk(mcm_pkg::REG_IOC, {24'h0, ioc}, 2'h0);
   endtask : wcfg

   function automatic logic pt(input logic [31:0] row, input logic [15:0] a);
      return ((row[15:0] & ~a) == 16'h0) && ((row[31:16] & a) == 16'h0);
   endfunction : pt

   // reference model of all eight cells, compared once the pin pipeline settles
   task automatic pins(input logic cplx);
      logic [15:0] a;
      logic        s;
      logic        en;
      ded_drv <= 8'($urandom);
      aux_drv <= 2'($urandom);
      io_drv  <= 8'($urandom);
      repeat (5) @(posedge clk_in);
      @(negedge clk_in);
      a = {aux_drv[0], 6'h0, aux_drv[1], ded_drv};
      for (int k = 0; k < 8; k++) begin
         s = 1'b0;
         for (int t = 0; t < (cplx ? 7 : 8); t++) s |= pt(fz[k*8+t], a);
         en = cplx ? pt(fz[k*8+7], a) : ~ioc[k];
         chk(32'(pin_oe_n[k]), {31'h0, ~en});
         if (en) chk(32'(pin_out[k]), 32'(s ^ pol[k]));
      end
   endtask : pins

   initial begin
      sys_rst_in = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      adr = 5'h0;
      wd = 32'h0;
      ded_drv = 8'h0;
      io_drv = 8'h0;
      aux_drv = 2'h0;
      void'($urandom(87));
      repeat (3) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      rchk(mcm_pkg::REG_MODE, 32'h1);
      rchk(mcm_pkg::REG_POL, 32'h0);
      rchk(mcm_pkg::REG_IOC, 32'h0);
      rchk(mcm_pkg::REG_SIG_LO, 32'h0);
      rchk(mcm_pkg::REG_SIG_HI, 32'h0);
      bus(1'b0, 5'h02, 32'h0);
      chk(q, 32'h0);
      chk(32'(r), 32'h3);
      sig_lo = $urandom;
      sig_hi = $urandom;
      wchk(mcm_pkg::REG_SIG_LO, sig_lo, 2'h0);
      wchk(mcm_pkg::REG_SIG_HI, sig_hi, 2'h0);
      rchk(mcm_pkg::REG_SIG_LO, sig_lo);
      rchk(mcm_pkg::REG_SIG_HI, sig_hi);
      // registered and undefined codes are stored but flagged, and no cell drives then
      wchk(mcm_pkg::REG_MODE, 32'h2, 2'h0);
      rchk(mcm_pkg::REG_MODE, 32'h2);
      chk(32'(fault), 32'h1);
      chk(32'(pin_oe_n), 32'hff);
      wchk(mcm_pkg::REG_MODE, 32'h0, 2'h0);
      rchk(mcm_pkg::REG_MODE, 32'h0);
      chk(32'(fault), 32'h1);
      wchk(mcm_pkg::REG_MODE, 32'h1, 2'h0);
      rchk(mcm_pkg::REG_MODE, 32'h1);
      chk(32'(fault), 32'h0);
      wchk(mcm_pkg::REG_IOC, 32'h08, 2'h2);
      wchk(mcm_pkg::REG_IOC, 32'h10, 2'h2);
      rchk(mcm_pkg::REG_IOC, 32'h0);
      // term 0 reads the dedicated pin with the cell's number, term 7 pin 7, the rest can never be true
      for (int i = 0; i < 64; i++) begin
         rowset(i, (i % 8 == 0) ? 32'h1 << (i / 8) : (i % 8 == 7) ? 32'h80 : 32'h00010001);
      end
      for (int n = 0; n < 6; n++) begin
         wcfg(8'he7);
         pins(1'b0);
      end
      // an outer input cell blocks the change to complex mode
      wchk(mcm_pkg::REG_IOC, 32'h01, 2'h0);
      wchk(mcm_pkg::REG_MODE, 32'h3, 2'h2);
      rchk(mcm_pkg::REG_MODE, 32'h1);
      wchk(mcm_pkg::REG_IOC, 32'h00, 2'h0);
      wchk(mcm_pkg::REG_MODE, 32'h3, 2'h0);
      rchk(mcm_pkg::REG_MODE, 32'h3);
      wchk(mcm_pkg::REG_IOC, 32'h01, 2'h2);
      wchk(mcm_pkg::REG_IOC, 32'h80, 2'h2);
      wchk(mcm_pkg::REG_IOC, 32'h7e, 2'h0);
      rowset(9, 32'h8000);
      rowset(18, 32'h0100);
      for (int n = 0; n < 8; n++) begin
         wcfg(8'h7e);
         pins(1'b1);
      end
      end_of_test();
   end
endmodule : tb_macrocell_complex_simple_modes
`default_nettype wire
